// *** include/lsir_pkg.sv ***
// Shared constants and types for the light sensor readout link
package lsir_pkg;
  // Identity and bus address, arbitrary values
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [3:0] PART_NUM = 4'h3;
  localparam logic [3:0] REV_NUM  = 4'h1;
  // Register pointers
  localparam logic [3:0] REG_CONTROL  = 4'h0;
  localparam logic [3:0] REG_THR_LO_L = 4'h2;
  localparam logic [3:0] REG_THR_LO_U = 4'h3;
  localparam logic [3:0] REG_THR_HI_L = 4'h4;
  localparam logic [3:0] REG_THR_HI_U = 4'h5;
  localparam logic [3:0] REG_IRQ_CTRL = 4'h6;
  localparam logic [3:0] REG_IDENT    = 4'hA;
  localparam logic [3:0] REG_CH0_L    = 4'hC;
  localparam logic [3:0] REG_CH0_U    = 4'hD;
  localparam logic [3:0] REG_CH1_L    = 4'hE;
  localparam logic [3:0] REG_CH1_U    = 4'hF;
  // Command byte fields
  localparam int CMD_SELECT_BIT = 7;
  localparam int CMD_CLEAR_BIT  = 6;
  localparam int CMD_WORD_BIT   = 5;
  // Interrupt control fields
  localparam int MODE_LSB    = 4;
  localparam int PERSIST_LSB = 0;
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_LEVEL = 2'h1;
  localparam logic [1:0] MODE_TEST  = 2'h3;
  localparam logic [1:0] POWER_ON   = 2'h3;
  // Reset values
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [1:0]  CTRL_RESET = 2'h0;
  // Timing
  localparam int CLK_MHZ       = 250;
  localparam int INTEG_TIME_MS = 400;
  localparam int INTEG_CYCLES  = INTEG_TIME_MS * 1000 * CLK_MHZ;
  localparam int SCL_KHZ       = 400;
  localparam int SCL_QUARTER   = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  // Host register offsets and fields
  localparam logic [1:0] HOST_CMD    = 2'h0;
  localparam logic [1:0] HOST_WDATA  = 2'h1;
  localparam logic [1:0] HOST_STATUS = 2'h2;
  localparam logic [1:0] HOST_RDATA  = 2'h3;
  localparam int HCMD_OP_LSB  = 0;
  localparam int HCMD_PTR_LSB = 4;
  typedef enum logic [2:0] {
    OP_SEND, OP_CLEAR, OP_WR_BYTE, OP_WR_WORD, OP_RD_BYTE, OP_RD_WORD
  } lsir_op_t;
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_WDAT, S_WACK, S_RDAT, S_RACK} lsir_slave_t;
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} lsir_master_t;
endpackage

// *** include/lsir_link_if.sv ***
// Two-wire link and interrupt pin between host and sensor
`timescale 1ns/10ps
interface lsir_link_if;
  logic host_scl_o;
  logic host_scl_oe_b;
  logic host_sda_o;
  logic host_sda_oe_b;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  logic dev_int_o;
  logic dev_int_oe_b;
  logic scl_i;
  logic sda_i;
  logic int_i;
  // Wired-AND lines with pull-ups
  assign scl_i = ~(~host_scl_oe_b & ~host_scl_o);
  assign sda_i = ~((~host_sda_oe_b & ~host_sda_o) | (~dev_sda_oe_b & ~dev_sda_o));
  assign int_i = ~(~dev_int_oe_b & ~dev_int_o);
  modport dev (input scl_i, sda_i, output dev_sda_o, dev_sda_oe_b, dev_int_o, dev_int_oe_b);
  modport host (input sda_i, int_i, output host_scl_o, host_scl_oe_b, host_sda_o,
                host_sda_oe_b);
endinterface

// *** verilog/lsir_dev.sv ***
// Sensor end: link slave, thresholds, interrupt and result registers
// Summary of operation
// - Interrupt when channel 0 at or below low
// - Interrupt when channel 0 above high threshold
// - Thresholds built from byte pairs 2/3, 4/5
// - Threshold bytes reset to zero
// - Persistence zero: interrupt every conversion
// - Persistence one: first out-of-window result
// - Persistence N: N consecutive out-of-window results
// - Level mode tests latest conversion result
// - Active-low interrupt held until clear command
// - Mode field 00 off, 01 level, 10 reserved
// - Mode 11 sets interrupt at once
// - Host writes reserved bits as zero
// - First byte with MSB set is command
// - Constant identity register, part and revision
// - Channel results in byte pairs, reset zero
// - Lower-byte read latches upper byte to shadow
// - Upper-byte read returns shadowed value
// - Host reads lower byte before upper
// - Host may read result as one word
// - Start powered down; 03h powers up
// - Convert both channels each integration period
// - Command bit 6 clears pending interrupt
// - Command bit 7 set, pointer in 3:0
`timescale 1ns/10ps
module lsir_dev #(
  parameter int INTEG_CYCLES = lsir_pkg::INTEG_CYCLES
) (
  // Clock, reset and enable
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Link and interrupt pin
  lsir_link_if.dev         link,
  // Converter front end
  input  wire logic [15:0] chan0_sample,
  input  wire logic [15:0] chan1_sample,
  // Status
  output logic             powered,
  output logic             conv_done
);
  logic                 scl_m, scl_s, scl_p;
  logic                 sda_m, sda_s, sda_p;
  lsir_pkg::lsir_slave_t state;
  logic [3:0]           cnt;
  logic [7:0]           sr;
  logic                 rw;
  logic                 nack;
  logic                 first;
  logic [3:0]           idx;
  logic [3:0]           ptr;
  logic [7:0]           thr_lo_l, thr_lo_u, thr_hi_l, thr_hi_u;
  logic [7:0]           irq_ctrl;
  logic [1:0]           ctrl;
  logic [15:0]          res0, res1;
  logic [7:0]           shadow0, shadow1;
  logic [26:0]          integ_cnt;
  logic [3:0]           persist_cnt;
  logic                 pending;
  logic [7:0]           rdata;

  // Pin synchronisers with one extra stage for edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else if (clk_en) begin
      scl_m <= link.scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= link.sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // Bus conditions
  wire start_cond = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_cond  = scl_s & scl_p & ~sda_p & sda_s;
  wire scl_rise   = scl_s & ~scl_p;
  wire scl_fall   = ~scl_s & scl_p;
  wire [3:0] cur_addr = ptr + idx;
  wire byte_in    = scl_fall && state == lsir_pkg::S_WDAT && cnt == 4'h8;
  wire cmd_fire   = byte_in && first && sr[lsir_pkg::CMD_SELECT_BIT];
  wire data_fire  = byte_in && !cmd_fire;
  wire rd_take    = scl_fall && ((state == lsir_pkg::S_AACK && rw) ||
                                 (state == lsir_pkg::S_RACK && !nack));

  // Slave byte engine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= lsir_pkg::S_IDLE;
      cnt <= 4'h0;
      sr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      first <= 1'b0;
      idx <= 4'h0;
      link.dev_sda_oe_b <= 1'b1;
    end else if (clk_en) begin
      if (start_cond) begin
        state <= lsir_pkg::S_ADDR;
        cnt <= 4'h0;
        idx <= 4'h0;
        first <= 1'b1;
        link.dev_sda_oe_b <= 1'b1;
      end else if (stop_cond) begin
        state <= lsir_pkg::S_IDLE;
        link.dev_sda_oe_b <= 1'b1;
      end else if (scl_rise) begin
        if ((state == lsir_pkg::S_ADDR || state == lsir_pkg::S_WDAT) && cnt != 4'h8) begin
          sr <= {sr[6:0], sda_s};
          cnt <= cnt + 4'h1;
        end
        if (state == lsir_pkg::S_RACK) begin
          nack <= sda_s;
        end
      end else if (scl_fall) begin
        case (state)
          lsir_pkg::S_ADDR: begin
            if (cnt == 4'h8 && sr[7:1] == lsir_pkg::DEV_ADDR) begin
              state <= lsir_pkg::S_AACK;
              rw <= sr[0];
              link.dev_sda_oe_b <= 1'b0;
            end else if (cnt == 4'h8) begin
              state <= lsir_pkg::S_IDLE;
            end
          end
          lsir_pkg::S_AACK, lsir_pkg::S_RACK: begin
            if (state == lsir_pkg::S_AACK && !rw) begin
              state <= lsir_pkg::S_WDAT;
              cnt <= 4'h0;
              link.dev_sda_oe_b <= 1'b1;
            end else if (state == lsir_pkg::S_RACK && nack) begin
              state <= lsir_pkg::S_IDLE;
              link.dev_sda_oe_b <= 1'b1;
            end else begin
              state <= lsir_pkg::S_RDAT;
              sr <= {rdata[6:0], 1'b0};
              link.dev_sda_oe_b <= rdata[7];
              cnt <= 4'h1;
              idx <= idx + 4'h1;
            end
          end
          lsir_pkg::S_WDAT: begin
            if (cnt == 4'h8) begin
              state <= lsir_pkg::S_WACK;
              link.dev_sda_oe_b <= 1'b0;
              first <= 1'b0;
              if (!cmd_fire) begin
                idx <= idx + 4'h1;
              end
            end
          end
          lsir_pkg::S_WACK: begin
            state <= lsir_pkg::S_WDAT;
            cnt <= 4'h0;
            link.dev_sda_oe_b <= 1'b1;
          end
          lsir_pkg::S_RDAT: begin
            if (cnt == 4'h8) begin
              state <= lsir_pkg::S_RACK;
              link.dev_sda_oe_b <= 1'b1;
            end else begin
              link.dev_sda_oe_b <= sr[7];
              sr <= {sr[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= 4'h0;
    end else if (clk_en && cmd_fire) begin
      ptr <= sr[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= lsir_pkg::CTRL_RESET;
      thr_lo_l <= lsir_pkg::BYTE_RESET;
      thr_lo_u <= lsir_pkg::BYTE_RESET;
      thr_hi_l <= lsir_pkg::BYTE_RESET;
      thr_hi_u <= lsir_pkg::BYTE_RESET;
      irq_ctrl <= lsir_pkg::BYTE_RESET;
    end else if (clk_en && data_fire) begin
      case (cur_addr)
        lsir_pkg::REG_CONTROL:  ctrl <= sr[1:0];
        lsir_pkg::REG_THR_LO_L: thr_lo_l <= sr;
        lsir_pkg::REG_THR_LO_U: thr_lo_u <= sr;
        lsir_pkg::REG_THR_HI_L: thr_hi_l <= sr;
        lsir_pkg::REG_THR_HI_U: thr_hi_u <= sr;
        lsir_pkg::REG_IRQ_CTRL: irq_ctrl <= sr;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (cur_addr)
      lsir_pkg::REG_CONTROL:  rdata = {6'h00, ctrl};
      lsir_pkg::REG_THR_LO_L: rdata = thr_lo_l;
      lsir_pkg::REG_THR_LO_U: rdata = thr_lo_u;
      lsir_pkg::REG_THR_HI_L: rdata = thr_hi_l;
      lsir_pkg::REG_THR_HI_U: rdata = thr_hi_u;
      lsir_pkg::REG_IRQ_CTRL: rdata = irq_ctrl;
      lsir_pkg::REG_IDENT:    rdata = {lsir_pkg::PART_NUM, lsir_pkg::REV_NUM};
      lsir_pkg::REG_CH0_L:    rdata = res0[7:0];
      lsir_pkg::REG_CH0_U:    rdata = shadow0;
      lsir_pkg::REG_CH1_L:    rdata = res1[7:0];
      lsir_pkg::REG_CH1_U:    rdata = shadow1;
      default:                rdata = 8'h00;
    endcase
  end

  // shadow the upper byte on lower read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shadow0 <= lsir_pkg::BYTE_RESET;
      shadow1 <= lsir_pkg::BYTE_RESET;
    end else if (clk_en && rd_take) begin
      if (cur_addr == lsir_pkg::REG_CH0_L) begin
        shadow0 <= res0[15:8];
      end
      if (cur_addr == lsir_pkg::REG_CH1_L) begin
        shadow1 <= res1[15:8];
      end
    end
  end

  wire integ_end = powered && integ_cnt == 27'(INTEG_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      powered <= 1'b0;
      integ_cnt <= 27'h0;
      conv_done <= 1'b0;
      res0 <= lsir_pkg::DATA_RESET;
      res1 <= lsir_pkg::DATA_RESET;
    end else if (clk_en) begin
      powered <= ctrl == lsir_pkg::POWER_ON;
      conv_done <= integ_end;
      if (!powered || integ_end) begin
        integ_cnt <= 27'h0;
      end else begin
        integ_cnt <= integ_cnt + 27'h1;
      end
      if (integ_end) begin
        res0 <= chan0_sample;
        res1 <= chan1_sample;
      end
    end
  end

  // window test on channel 0 only
  wire out_win = res0 <= {thr_lo_u, thr_lo_l} || res0 > {thr_hi_u, thr_hi_l};
  wire [3:0] persist = irq_ctrl[lsir_pkg::PERSIST_LSB +: 4];
  wire [1:0] mode    = irq_ctrl[lsir_pkg::MODE_LSB +: 2];
  wire [3:0] next_persist_cnt = !out_win ? 4'h0 :
                                (persist_cnt == 4'hF) ? 4'hF : persist_cnt + 4'h1;
  wire irq_event = conv_done && mode == lsir_pkg::MODE_LEVEL &&
                   (persist == 4'h0 || (out_win && next_persist_cnt >= persist));
  wire test_set  = data_fire && cur_addr == lsir_pkg::REG_IRQ_CTRL &&
                   sr[lsir_pkg::MODE_LSB +: 2] == lsir_pkg::MODE_TEST;
  wire irq_clear = cmd_fire && sr[lsir_pkg::CMD_CLEAR_BIT];

  // Persistence counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      persist_cnt <= 4'h0;
    end else if (clk_en && conv_done) begin
      persist_cnt <= next_persist_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
      link.dev_int_oe_b <= 1'b1;
      link.dev_int_o <= 1'b0;
      link.dev_sda_o <= 1'b0;
    end else if (clk_en) begin
      pending <= irq_event | test_set | (pending & ~irq_clear);
      link.dev_int_oe_b <= ~(pending && mode != lsir_pkg::MODE_OFF);
    end
  end
endmodule

// *** verilog/lsir_host.sv ***
// Host end: register port and two-wire link master
`timescale 1ns/10ps
module lsir_host (
  // Clock, reset and enable
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Link and interrupt pin
  lsir_link_if.host        link,
  // Software register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);
  logic                   sda_m, sda_s, int_m, int_s;
  lsir_pkg::lsir_master_t state;
  lsir_pkg::lsir_op_t     op;
  logic [3:0]             ptr;
  logic [15:0]            wdata, rdata;
  logic                   nack, txnb;
  logic [1:0]             ph, stage, last;
  logic [3:0]             bitn;
  logic [7:0]             qcnt, rx, tx_cur;

  wire busy    = state != lsir_pkg::H_IDLE;
  wire go      = reg_wr && reg_addr == lsir_pkg::HOST_CMD && !busy;
  wire tick    = qcnt == 8'(lsir_pkg::SCL_QUARTER - 1);
  wire is_read = op == lsir_pkg::OP_RD_BYTE || op == lsir_pkg::OP_RD_WORD;
  wire rx_mode = txnb && stage != 2'h0;
  wire is_word = op == lsir_pkg::OP_WR_WORD || op == lsir_pkg::OP_RD_WORD;

  // byte to send and last byte index
  always_comb begin
    case (stage)
      2'h0:    tx_cur = {lsir_pkg::DEV_ADDR, txnb};
      2'h1:    tx_cur = {1'b1, op == lsir_pkg::OP_CLEAR, is_word, 1'b0, ptr};
      2'h2:    tx_cur = wdata[7:0];
      default: tx_cur = wdata[15:8];
    endcase
    if (txnb) begin
      last = is_word ? 2'h2 : 2'h1;
    end else begin
      last = op == lsir_pkg::OP_WR_WORD ? 2'h3 : op == lsir_pkg::OP_WR_BYTE ? 2'h2 : 2'h1;
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sda_m, sda_s, int_m, int_s} <= 4'hF;
    end else if (clk_en) begin
      sda_m <= link.sda_i;
      sda_s <= sda_m;
      int_m <= link.int_i;
      int_s <= int_m;
    end
  end

  // Quarter bit timer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      qcnt <= 8'h00;
    end else if (clk_en) begin
      qcnt <= (!busy || tick) ? 8'h00 : qcnt + 8'h01;
    end
  end

  // Software registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdata <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == lsir_pkg::HOST_WDATA) begin
        wdata <= reg_wdata;
      end
      case ({reg_rd, reg_addr})
        {1'b1, lsir_pkg::HOST_WDATA}:  reg_rdata <= wdata;
        {1'b1, lsir_pkg::HOST_STATUS}: reg_rdata <= {13'h0000, ~int_s, nack, busy};
        {1'b1, lsir_pkg::HOST_RDATA}:  reg_rdata <= rdata;
        default:                       reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Link sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= lsir_pkg::H_IDLE;
      op <= lsir_pkg::OP_SEND;
      ptr <= 4'h0;
      nack <= 1'b0;
      txnb <= 1'b0;
      ph <= 2'h0;
      stage <= 2'h0;
      bitn <= 4'h0;
      rx <= 8'h00;
      rdata <= 16'h0000;
      link.host_scl_o <= 1'b0;
      link.host_sda_o <= 1'b0;
      link.host_scl_oe_b <= 1'b1;
      link.host_sda_oe_b <= 1'b1;
    end else if (clk_en) begin
      if (go) begin
        state <= lsir_pkg::H_START;
        op <= lsir_pkg::lsir_op_t'(reg_wdata[lsir_pkg::HCMD_OP_LSB +: 3]);
        ptr <= reg_wdata[lsir_pkg::HCMD_PTR_LSB +: 4];
        nack <= 1'b0;
        txnb <= 1'b0;
        stage <= 2'h0;
        ph <= 2'h0;
      end else if (busy && tick) begin
        ph <= ph + 2'h1;
        case (state)
          lsir_pkg::H_START: begin
            if (ph == 2'h1) link.host_sda_oe_b <= 1'b0;
            if (ph == 2'h2) link.host_scl_oe_b <= 1'b0;
            if (ph == 2'h3) begin
              state <= lsir_pkg::H_BIT;
              bitn <= 4'h0;
            end
          end
          lsir_pkg::H_BIT: begin
            if (ph == 2'h0) begin
              if (bitn == 4'h8) begin
                link.host_sda_oe_b <= ~rx_mode || stage == last;
              end else begin
                link.host_sda_oe_b <= rx_mode || tx_cur[3'h7 - bitn[2:0]];
              end
            end
            if (ph == 2'h1) link.host_scl_oe_b <= 1'b1;
            if (ph == 2'h2 && bitn == 4'h8 && !rx_mode) nack <= nack | sda_s;
            if (ph == 2'h2 && bitn != 4'h8) rx <= {rx[6:0], sda_s};
            if (ph == 2'h3) begin
              link.host_scl_oe_b <= 1'b0;
              bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
              if (bitn == 4'h8 && rx_mode && stage == 2'h1) rdata <= {8'h00, rx};
              if (bitn == 4'h8 && rx_mode && stage == 2'h2) rdata[15:8] <= rx;
              if (bitn == 4'h8 && stage == last) state <= lsir_pkg::H_STOP;
              if (bitn == 4'h8 && stage != last) stage <= stage + 2'h1;
            end
          end
          lsir_pkg::H_STOP: begin
            if (ph == 2'h0) link.host_sda_oe_b <= 1'b0;
            if (ph == 2'h1) link.host_scl_oe_b <= 1'b1;
            if (ph == 2'h2) link.host_sda_oe_b <= 1'b1;
            if (ph == 2'h3 && is_read && !txnb) begin
              txnb <= 1'b1;
              stage <= 2'h0;
              state <= lsir_pkg::H_START;
            end else if (ph == 2'h3) begin
              state <= lsir_pkg::H_IDLE;
            end
          end
          default: state <= lsir_pkg::H_IDLE;
        endcase
      end
    end
  end
endmodule

// *** dv/lsir_link_checker.sv ***
// Protocol checker for the sensor link and interrupt pin
`timescale 1ns/10ps
module lsir_link_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Driven values and enables
  input wire logic host_scl_o,
  input wire logic host_scl_oe_b,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_b,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_b,
  input wire logic dev_int_o,
  input wire logic dev_int_oe_b,
  // Resolved lines
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic int_i
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Device keeps a bit low for eight cycles
  sequence dev_drive_held;
    !dev_sda_oe_b [*8];
  endsequence
  // Interrupt pin stays driven for eight cycles once set
  sequence irq_held;
    !dev_int_oe_b [*8];
  endsequence
  od_levels_a: assert property (!(host_scl_o | host_sda_o | dev_sda_o | dev_int_o))
    else $error("open-drain value not zero");
  idle_reset_a: assert property ($rose(rst_b) |-> scl_i && sda_i && int_i)
    else $error("line not idle after reset");
  // device data changes with clock low
  dev_sda_phase_a: assert property ($changed(dev_sda_oe_b) |-> !scl_i)
    else $error("device data changed with clock high");
  // device bit held for at least eight cycles
  ack_hold_a: assert property ($fell(dev_sda_oe_b) |-> dev_drive_held)
    else $error("device bit too short");
  // no two drivers while clock high
  no_contend_a: assert property (scl_i |-> host_sda_oe_b || dev_sda_oe_b)
    else $error("both ends drive data");
  irq_release_a: assert property ($rose(dev_int_oe_b) |-> !scl_i)
    else $error("interrupt released outside a command");
  irq_hold_a: assert property ($fell(dev_int_oe_b) |-> irq_held)
    else $error("interrupt pulse too short");
  start_host_a: assert property ($fell(sda_i) && scl_i |-> !host_sda_oe_b)
    else $error("start not made by host");
endmodule

// *** dv/testbench.sv ***
// Self-checking bench joining host and sensor ends
`timescale 1ns/10ps
module testbench;
  localparam int INTEG = 2000;
  logic        sys_clk;
  logic        rst_b;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] chan0_sample;
  logic [15:0] chan1_sample;
  logic [15:0] held;
  logic        hold;
  logic        powered;
  logic        conv_done;
  logic        rel;
  logic [31:0] seed;
  logic [15:0] v;
  int          fail_count;
  int          compares;
  int          n;
  int          pc;

  lsir_link_if link ();
  lsir_dev #(.INTEG_CYCLES(INTEG)) u_lsir_dev (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(1'b1), .link(link.dev), .chan0_sample(chan0_sample),
    .chan1_sample(chan1_sample), .powered(powered), .conv_done(conv_done));
  lsir_host u_lsir_host (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .link(link.host),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  lsir_link_checker u_lsir_link_checker (.sys_clk(sys_clk), .rst_b(rst_b),
    .host_scl_o(link.host_scl_o), .host_scl_oe_b(link.host_scl_oe_b),
    .host_sda_o(link.host_sda_o), .host_sda_oe_b(link.host_sda_oe_b),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe_b(link.dev_sda_oe_b), .dev_int_o(link.dev_int_o),
    .dev_int_oe_b(link.dev_int_oe_b), .scl_i(link.scl_i), .sda_i(link.sda_i),
    .int_i(link.int_i));

  // Stimulus sequence step
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Word formed from lower and upper result bytes
  function automatic logic [15:0] pair(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction
  // Channel 0 result outside the threshold window
  function automatic logic win_out(input logic [15:0] r, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return r <= lo || r > hi;
  endfunction
  // Hand-written results on and beside the window edges
  function automatic logic [15:0] corner(input int i);
    case (i)
      0:       return 16'h8001;
      1:       return 16'h8000;
      2:       return 16'h0000;
      default: return 16'hFFFF;
    endcase
  endfunction

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Fresh samples every cycle unless one is held
  always @(posedge sys_clk) begin
    seed         <= xs(seed);
    chan0_sample <= hold ? held : seed[15:0];
    chan1_sample <= seed[31:16];
  end
  // Notes any release of the interrupt line
  always @(posedge link.int_i) rel = 1'b1;

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One link transfer, polled until idle
  task automatic xfer(input logic [2:0] op, input logic [3:0] ptr, input logic [15:0] d);
    int k;
    wr(lsir_pkg::HOST_WDATA, d);
    wr(lsir_pkg::HOST_CMD, {8'h00, ptr, 1'b0, op});
    v = 16'h0001;
    for (k = 0; k < 20000 && v[0] !== 1'b0; k++) rd(lsir_pkg::HOST_STATUS, v);
    chk("link status", v & 16'h0003, 16'h0000);
  endtask
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog, a little beyond the expected run length
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    results;
  end

  // Main sequence
  initial begin
    seed = 32'hBBC4AF2B;
    rst_b = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chan0_sample = 16'h0000;
    chan1_sample = 16'h0000;
    held = 16'h0000;
    hold = 1'b0;
    rel = 1'b0;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    // high threshold 8000h, level mode, persistence three
    xfer(lsir_pkg::OP_WR_WORD, lsir_pkg::REG_THR_HI_U, 16'h1380);
    chk("powered", powered, 16'h0000);
    xfer(lsir_pkg::OP_WR_BYTE, lsir_pkg::REG_CONTROL, 16'h0003);
    chk("powered", powered, 16'h0001);
    $display("test power up done");
    // window edges, one held result per period
    n = 0;
    pc = 0;
    hold <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      held <= (i == 4) ? (seed[15:0] | 16'h8001) : corner(i);
      do begin tick; n++; end while (conv_done !== 1'b1 && n < 2 * INTEG);
      if (i > 0) chk("period", 16'(n), 16'(INTEG));
      pc = win_out(held, 16'h0000, 16'h8000) ? pc + 1 : 0;
      repeat (3) tick;
      chk("irq pin", 16'(link.int_i), (pc >= 3) ? 16'h0000 : 16'h0001);
      n = 3;
    end
    rd(lsir_pkg::HOST_STATUS, v);
    chk("status", v, 16'h0004);
    rd(lsir_pkg::HOST_CMD, v);
    chk("cmd read", v, 16'h0000);
    $display("test persistence done");
    // clear command releases, level mode sets again
    rel = 1'b0;
    xfer(lsir_pkg::OP_CLEAR, lsir_pkg::REG_CH0_L, 16'h0000);
    chk("released", 16'(rel), 16'h0001);
    repeat (INTEG + 4) tick;
    chk("irq again", 16'(link.int_i), 16'h0000);
    $display("test clear done");
    // word read of a held channel 0 result
    held <= seed[23:8];
    hold <= 1'b1;
    xfer(lsir_pkg::OP_RD_WORD, lsir_pkg::REG_CH0_L, 16'h0000);
    rd(lsir_pkg::HOST_RDATA, v);
    chk("chan0 word", v, pair(held[7:0], held[15:8]));
    $display("test readout done");
    results;
  end
endmodule
